// ---- verilog/sbw_pkg.sv ----
// Constants for the break, wake and synchronous master serial block.
// Assumes a 32-bit APB slave with byte addresses in the low eight bits.
package sbw_pkg;
    // ----------------------------------------
    // Register byte offsets
    // ----------------------------------------
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [7:0] ADDR_TXDATA = 8'h08;
    localparam logic [7:0] ADDR_RXDATA = 8'h0C;
    localparam logic [7:0] ADDR_BAUD = 8'h10;
    // ----------------------------------------
    // Control register fields
    // ----------------------------------------
    localparam int CTRL_WIDTH = 11;
    localparam int SERIAL_PORT_ENABLE = 0;
    localparam int CLOCKED_MODE = 1;
    localparam int CLOCK_SOURCE_MASTER = 2;
    localparam int TRANSMIT_ENABLE_BIT = 3;
    localparam int SEND_BREAK_REQUEST = 4;
    localparam int SINGLE_RECEIVE_ENABLE = 5;
    localparam int CONTINUOUS_RECEIVE_ENABLE = 6;
    localparam int WAKE_ON_LINE_ENABLE = 7;
    localparam int CLOCK_POLARITY_SELECT = 8;
    localparam int DATA_POLARITY_SELECT = 9;
    localparam int AUTO_BAUD_ENABLE = 10;
    localparam logic [CTRL_WIDTH-1:0] CTRL_RESET = 11'h000;
    // ----------------------------------------
    // Status register fields
    // ----------------------------------------
    localparam int ST_RECEIVE_INTERRUPT_FLAG = 0;
    localparam int ST_TRANSMIT_BUFFER_EMPTY_FLAG = 1;
    localparam int ST_TRANSMIT_SHIFT_EMPTY = 2;
    localparam int ST_RECEIVER_IDLE_STATUS = 3;
    localparam int ST_FRAMING_ERROR_FLAG = 4;
    // ----------------------------------------
    // Frame shapes and reset values
    // ----------------------------------------
    localparam logic [3:0] ASYNC_FRAME_BITS = 4'hA;
    localparam logic [3:0] BREAK_FRAME_BITS = 4'hE;
    localparam logic [2:0] SYNC_LAST_BIT = 3'h7;
    localparam logic [2:0] ASYNC_LAST_DATA_BIT = 3'h7;
    localparam logic [15:0] BAUD_DIV_RESET = 16'h0010;
    localparam logic [7:0] RX_DATA_RESET = 8'h00;
    localparam logic [13:0] SHIFT_RESET = 14'h3FFF;

    typedef enum logic [1:0] {TX_IDLE, TX_ASYNC, TX_SYNC_LEAD, TX_SYNC_TRAIL} sbw_tx_state_t;
    typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} sbw_rx_state_t;
endpackage

// ---- verilog/sbw_top.sv ----
// Break, wake-on-line and synchronous master logic of a serial port.
// Assumes an APB master on i_ref_clk and a pad that resolves each pin from its enable.
//
// Register access over APB and the register offsets were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module sbw_top
    import sbw_pkg::*;
#(
    parameter logic [15:0] RESET_BAUD_DIV = BAUD_DIV_RESET
)
(
    input wire logic i_ref_clk,
    input wire logic i_reset_n,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [7:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    input wire logic i_receive_or_data_pin,
    output logic o_receive_or_data_pin,
    output logic o_receive_or_data_pin_oe,
    output logic o_transmit_or_clock_pin,
    output logic o_transmit_or_clock_pin_oe,
    output logic o_receive_interrupt_flag
);
    // ----------------------------------------
    // Register state
    // ----------------------------------------
    logic [CTRL_WIDTH-1:0] ctrl;
    logic [15:0] baud_div;
    logic [7:0] tx_buf;
    logic tx_buf_full;
    logic [7:0] rx_data;
    logic rx_flag;
    logic framing_error_flag;
    logic access_done;
    logic wr_ctrl;
    logic wr_tx;
    logic wr_baud;
    logic rd_rx;
    logic mapped;
    logic break_done;
    logic wake_end;
    logic wake_evt;
    logic rx_done;
    logic rx_stop_bad;
    logic tx_load;

    // The access completes on the edge where our own registered ready is seen
    assign access_done = i_psel && i_penable && o_pready;
    assign wr_ctrl = access_done && i_pwrite && (i_paddr == ADDR_CTRL);
    assign wr_tx = access_done && i_pwrite && (i_paddr == ADDR_TXDATA);
    assign wr_baud = access_done && i_pwrite && (i_paddr == ADDR_BAUD);
    assign rd_rx = access_done && !i_pwrite && (i_paddr == ADDR_RXDATA);
    assign mapped = (i_paddr == ADDR_CTRL) || (i_paddr == ADDR_STATUS) || (i_paddr == ADDR_TXDATA)
        || (i_paddr == ADDR_RXDATA) || (i_paddr == ADDR_BAUD);

    logic serial_port_enable;
    logic sync_mode;
    logic sync_master;
    logic tx_mode;
    logic ckpol;
    logic dpol;
    logic wake_on_line_enable;
    assign serial_port_enable = ctrl[SERIAL_PORT_ENABLE];
    assign sync_mode = ctrl[CLOCKED_MODE];
    assign sync_master = serial_port_enable && sync_mode && ctrl[CLOCK_SOURCE_MASTER];
    assign tx_mode = !ctrl[SINGLE_RECEIVE_ENABLE] && !ctrl[CONTINUOUS_RECEIVE_ENABLE];
    assign ckpol = ctrl[CLOCK_POLARITY_SELECT];
    assign dpol = ctrl[DATA_POLARITY_SELECT];
    assign wake_on_line_enable = ctrl[WAKE_ON_LINE_ENABLE];

    // ----------------------------------------
    // Receive pin synchroniser and edges
    // ----------------------------------------
    logic rx_meta;
    logic rx_sync;
    logic rx_prev;
    logic rx_line;
    logic rx_fall;
    logic rx_rise;

    always_ff @(posedge i_ref_clk)
    begin
        if (!i_reset_n)
        begin
            rx_meta <= 1'b1;
            rx_sync <= 1'b1;
        end
        else
        begin
            rx_meta <= i_receive_or_data_pin;
            rx_sync <= rx_meta;
        end
    end

    assign rx_line = rx_sync ^ dpol;

    always_ff @(posedge i_ref_clk)
    begin
        if (!i_reset_n)
            rx_prev <= 1'b1;
        else
            rx_prev <= rx_line;
    end

    assign rx_fall = rx_prev && !rx_line;
    assign rx_rise = !rx_prev && rx_line;

    // ----------------------------------------
    // Wake on line activity
    // ----------------------------------------
    // Clocks never stop in this implementation, so the wake event is always caught
    // on i_ref_clk; a sleeping system must keep this clock alive to be woken.
    logic wake_seen;
    assign wake_evt = serial_port_enable && !sync_mode && wake_on_line_enable && !wake_seen && rx_fall;
    assign wake_end = serial_port_enable && !sync_mode && wake_on_line_enable && wake_seen && rx_rise;

    always_ff @(posedge i_ref_clk)
    begin
        if (!i_reset_n)
            wake_seen <= 1'b0;
        else if (!wake_on_line_enable || wake_end)
            wake_seen <= 1'b0;
        else if (wake_evt)
            wake_seen <= 1'b1;
    end

    // ----------------------------------------
    // Control and baud registers
    // ----------------------------------------
    // Auto-baud stays armed across the wake, so the measurement applies to the
    // character after the break; the measuring logic sits outside this block.
    always_ff @(posedge i_ref_clk)
    begin
        if (!i_reset_n)
            ctrl <= CTRL_RESET;
        else
        begin
            if (wr_ctrl)
                ctrl <= i_pwdata[CTRL_WIDTH-1:0];
            if (break_done)
                ctrl[SEND_BREAK_REQUEST] <= 1'b0;
            if (wake_end)
                ctrl[WAKE_ON_LINE_ENABLE] <= 1'b0;
        end
    end

    always_ff @(posedge i_ref_clk)
    begin
        if (!i_reset_n)
            baud_div <= RESET_BAUD_DIV;
        else if (wr_baud)
            baud_div <= i_pwdata[15:0];
    end

    // ----------------------------------------
    // Transmit buffer
    // ----------------------------------------
    sbw_tx_state_t tx_state;
    logic [13:0] tx_shift;
    logic [3:0] tx_bits;
    logic [3:0] tx_len;
    logic tx_is_break;
    logic [15:0] tx_cnt;
    logic tx_tick;

    // A byte moves to the shifter only when it is idle; otherwise it waits
    assign tx_load = tx_buf_full && (tx_state == TX_IDLE) && serial_port_enable && ctrl[TRANSMIT_ENABLE_BIT]
        && (!sync_mode || (sync_master && tx_mode));

    always_ff @(posedge i_ref_clk)
    begin
        if (!i_reset_n)
        begin
            tx_buf <= RX_DATA_RESET;
            tx_buf_full <= 1'b0;
        end
        else if (tx_load)
            tx_buf_full <= 1'b0;
        else if (wr_tx && !tx_buf_full)
        begin
            tx_buf <= i_pwdata[7:0];
            tx_buf_full <= 1'b1;
        end
    end

    // ----------------------------------------
    // Bit timing and transmit shifter
    // ----------------------------------------
    assign tx_tick = (tx_cnt == baud_div - 16'h0001);

    always_ff @(posedge i_ref_clk)
    begin
        if (!i_reset_n || tx_load || tx_tick)
            tx_cnt <= 16'h0000;
        else
            tx_cnt <= tx_cnt + 16'h0001;
    end

    always_ff @(posedge i_ref_clk)
    begin
        if (!i_reset_n)
        begin
            tx_state <= TX_IDLE;
            tx_shift <= SHIFT_RESET;
            tx_bits <= 4'h0;
            tx_len <= ASYNC_FRAME_BITS;
            tx_is_break <= 1'b0;
            break_done <= 1'b0;
        end
        else
        begin
            break_done <= 1'b0;
            case (tx_state)
                TX_IDLE:
                begin
                    tx_bits <= 4'h0;
                    if (tx_load && sync_mode)
                    begin
                        tx_shift <= {6'h3F, tx_buf};
                        tx_state <= TX_SYNC_LEAD;
                    end
                    else if (tx_load && ctrl[SEND_BREAK_REQUEST] && !break_done)
                    begin
                        // Written value discarded; start plus twelve zeros, then stop
                        tx_shift <= {1'b1, 13'h0000};
                        tx_len <= BREAK_FRAME_BITS;
                        tx_is_break <= 1'b1;
                        tx_state <= TX_ASYNC;
                    end
                    else if (tx_load)
                    begin
                        tx_shift <= {5'h1F, tx_buf, 1'b0};
                        tx_len <= ASYNC_FRAME_BITS;
                        tx_is_break <= 1'b0;
                        tx_state <= TX_ASYNC;
                    end
                end
                TX_ASYNC:
                begin
                    if (tx_tick)
                    begin
                        tx_shift <= {1'b1, tx_shift[13:1]};
                        tx_bits <= tx_bits + 4'h1;
                        if (tx_bits == tx_len - 4'h1)
                        begin
                            tx_state <= TX_IDLE;
                            break_done <= tx_is_break;
                        end
                    end
                end
                TX_SYNC_LEAD:
                begin
                    if (tx_tick)
                        tx_state <= TX_SYNC_TRAIL;
                end
                TX_SYNC_TRAIL:
                begin
                    if (tx_tick)
                    begin
                        if (tx_bits[2:0] == SYNC_LAST_BIT)
                            tx_state <= TX_IDLE;
                        else
                        begin
                            // Next bit appears together with the next leading edge
                            tx_shift <= {1'b1, tx_shift[13:1]};
                            tx_bits <= tx_bits + 4'h1;
                            tx_state <= TX_SYNC_LEAD;
                        end
                    end
                end
                default:
                    tx_state <= TX_IDLE;
            endcase
        end
    end

    // ----------------------------------------
    // Asynchronous receiver
    // ----------------------------------------
    sbw_rx_state_t rx_state;
    logic [15:0] rx_cnt;
    logic [2:0] rx_bits;
    logic [7:0] rx_shift;
    logic rx_enabled;
    logic rx_half;
    logic rx_full;

    // Wake enable parks the receiver so the break is not taken as data
    assign rx_enabled = serial_port_enable && !sync_mode && ctrl[CONTINUOUS_RECEIVE_ENABLE] && !wake_on_line_enable;
    assign rx_half = (rx_cnt == {1'b0, baud_div[15:1]});
    assign rx_full = (rx_cnt == baud_div - 16'h0001);
    assign rx_stop_bad = !rx_line;

    always_ff @(posedge i_ref_clk)
    begin
        if (!i_reset_n)
        begin
            rx_state <= RX_IDLE;
            rx_cnt <= 16'h0000;
            rx_bits <= 3'h0;
            rx_shift <= RX_DATA_RESET;
            rx_done <= 1'b0;
        end
        else
        begin
            rx_done <= 1'b0;
            rx_cnt <= rx_cnt + 16'h0001;
            if (!rx_enabled)
                rx_state <= RX_IDLE;
            else
            begin
                case (rx_state)
                    RX_IDLE:
                    begin
                        rx_cnt <= 16'h0000;
                        rx_bits <= 3'h0;
                        if (rx_fall)
                            rx_state <= RX_START;
                    end
                    RX_START:
                    begin
                        if (rx_half)
                        begin
                            rx_cnt <= 16'h0000;
                            rx_state <= rx_line ? RX_IDLE : RX_DATA;
                        end
                    end
                    RX_DATA:
                    begin
                        if (rx_full)
                        begin
                            rx_cnt <= 16'h0000;
                            rx_shift <= {rx_line, rx_shift[7:1]};
                            rx_bits <= rx_bits + 3'h1;
                            if (rx_bits == ASYNC_LAST_DATA_BIT)
                                rx_state <= RX_STOP;
                        end
                    end
                    RX_STOP:
                    begin
                        if (rx_full)
                        begin
                            rx_done <= 1'b1;
                            rx_state <= RX_IDLE;
                        end
                    end
                    default:
                        rx_state <= RX_IDLE;
                endcase
            end
        end
    end

    // A break yields 00h with a low stop bit, hence the framing error
    always_ff @(posedge i_ref_clk)
    begin
        if (!i_reset_n)
        begin
            rx_data <= RX_DATA_RESET;
            framing_error_flag <= 1'b0;
        end
        else if (rx_done)
        begin
            rx_data <= rx_shift;
            framing_error_flag <= rx_stop_bad;
        end
    end

    // Set wins over the read-clear so an event in the read cycle survives
    always_ff @(posedge i_ref_clk)
    begin
        if (!i_reset_n)
            rx_flag <= 1'b0;
        else if (rx_done || wake_evt)
            rx_flag <= 1'b1;
        else if (rd_rx)
            rx_flag <= 1'b0;
    end

    // ----------------------------------------
    // APB read path
    // ----------------------------------------
    logic [31:0] rd_value;
    always_comb
    begin
        rd_value = 32'h0000_0000;
        case (i_paddr)
            ADDR_CTRL: rd_value[CTRL_WIDTH-1:0] = ctrl;
            ADDR_STATUS:
            begin
                rd_value[ST_RECEIVE_INTERRUPT_FLAG] = rx_flag;
                rd_value[ST_TRANSMIT_BUFFER_EMPTY_FLAG] = !tx_buf_full;
                rd_value[ST_TRANSMIT_SHIFT_EMPTY] = (tx_state == TX_IDLE);
                rd_value[ST_RECEIVER_IDLE_STATUS] = (rx_state == RX_IDLE);
                rd_value[ST_FRAMING_ERROR_FLAG] = framing_error_flag;
            end
            ADDR_RXDATA: rd_value[7:0] = rx_data;
            ADDR_BAUD: rd_value[15:0] = baud_div;
            default: rd_value = 32'h0000_0000;
        endcase
    end

    // One wait state keeps ready and read data straight from flip-flops
    always_ff @(posedge i_ref_clk)
    begin
        if (!i_reset_n)
        begin
            o_pready <= 1'b0;
            o_prdata <= 32'h0000_0000;
            o_pslverr <= 1'b0;
        end
        else
        begin
            o_pready <= i_psel && i_penable && !o_pready;
            o_prdata <= rd_value;
            o_pslverr <= i_psel && i_penable && !o_pready && !mapped;
        end
    end

    // ----------------------------------------
    // Pin drivers
    // ----------------------------------------
    always_ff @(posedge i_ref_clk)
    begin
        if (!i_reset_n)
        begin
            o_transmit_or_clock_pin <= 1'b1;
            o_transmit_or_clock_pin_oe <= 1'b0;
            o_receive_or_data_pin <= 1'b0;
            o_receive_or_data_pin_oe <= 1'b0;
            o_receive_interrupt_flag <= 1'b0;
        end
        else
        begin
            o_receive_interrupt_flag <= rx_flag;
            if (sync_master)
            begin
                // Clock leaves its idle level for the first half of every bit
                o_transmit_or_clock_pin <= (tx_state == TX_SYNC_LEAD) ? !ckpol : ckpol;
                o_transmit_or_clock_pin_oe <= 1'b1;
                o_receive_or_data_pin <= tx_shift[0] ^ dpol;
                o_receive_or_data_pin_oe <= tx_mode;
            end
            else
            begin
                o_transmit_or_clock_pin <= ((tx_state == TX_ASYNC) ? tx_shift[0] : 1'b1) ^ dpol;
                o_transmit_or_clock_pin_oe <= serial_port_enable && !sync_mode;
                o_receive_or_data_pin <= 1'b0;
                o_receive_or_data_pin_oe <= 1'b0;
            end
        end
    end
endmodule
`default_nettype wire

// ---- tb/sbw_node.sv ----
// Far-side node model: drives the receive line, decodes what the block sends.
// Assumes the bench sets bit_ns, ckpol and async_on before traffic starts.
`timescale 1ns/1ps
`default_nettype none
module sbw_node (
    input wire logic i_tx_pin,
    input wire logic i_tx_oe,
    input wire logic i_dt_pin,
    input wire logic i_dt_oe,
    output logic o_rx_line
);
    int bit_ns = 96;
    logic ckpol = 1'h0;
    logic async_on = 1'h0;
    int flen[$];
    logic [7:0] fbyte[$];
    logic [15:0] sbits = 16'h0000;
    int scount = 0;
    logic [13:0] fr;
    int k;
    logic tx_ln;
    // A released line floats to the bus pull-up
    assign tx_ln = i_tx_oe ? i_tx_pin : 1'h1;
    initial o_rx_line = 1'h1;
    task automatic send_low(input int n);
        o_rx_line = 1'h0;
        #(n * bit_ns);
        o_rx_line = 1'h1;
    endtask
    // Mid-bit sampling; a stop is the first high sample from bit nine on
    always @(negedge tx_ln)
    begin
        if (async_on)
        begin
            fr = 14'h0000;
            k = 0;
            #(bit_ns / 2);
            do
            begin
                #(bit_ns);
                k++;
                fr[k] = tx_ln;
            end
            while (!(k >= 9 && tx_ln) && k < 13);
            flen.push_back(tx_ln ? k + 1 : 0);
            fbyte.push_back(fr[8:1]);
        end
    end
    // Sync slave side takes data on the trailing clock edge
    always @(tx_ln)
    begin
        if (!async_on && i_dt_oe && tx_ln === ckpol)
        begin
            sbits = {i_dt_pin, sbits[15:1]};
            scount++;
        end
    end
endmodule
`default_nettype wire

// ---- tb/sbw_top_props.sv ----
// Port checker for the break, wake and synchronous master block.
// Assumes it is bound to sbw_top and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module sbw_top_props
    import sbw_pkg::*;
(
    input wire logic i_ref_clk,
    input wire logic i_reset_n,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [7:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    input wire logic [31:0] o_prdata,
    input wire logic o_pready,
    input wire logic o_pslverr,
    input wire logic i_receive_or_data_pin,
    input wire logic o_receive_or_data_pin,
    input wire logic o_receive_or_data_pin_oe,
    input wire logic o_transmit_or_clock_pin,
    input wire logic o_transmit_or_clock_pin_oe,
    input wire logic o_receive_interrupt_flag
);
    logic [CTRL_WIDTH-1:0] ctrl_sh;
    logic wake_sh;
    logic line_q;
    logic ctrl_wr;
    default clocking cb @(posedge i_ref_clk);
    endclocking
    default disable iff (!i_reset_n);
    assign ctrl_wr = o_pready && i_pwrite && i_paddr == ADDR_CTRL;
    // ----------------------------------------
    // Shadow state
    // ----------------------------------------
    always_ff @(posedge i_ref_clk)
    begin
        if (!i_reset_n)
            ctrl_sh <= CTRL_RESET;
        else if (ctrl_wr)
            ctrl_sh <= i_pwdata[CTRL_WIDTH-1:0];
    end
    // Wake only armed in async mode, disarmed by the next line rise
    always_ff @(posedge i_ref_clk)
    begin
        if (!i_reset_n)
            wake_sh <= 1'h0;
        else if (ctrl_wr)
            wake_sh <= i_pwdata[WAKE_ON_LINE_ENABLE] && !i_pwdata[CLOCKED_MODE];
        else if (i_receive_or_data_pin && !line_q)
            wake_sh <= 1'h0;
    end
    always_ff @(posedge i_ref_clk)
    begin
        line_q <= i_receive_or_data_pin;
    end
    // ----------------------------------------
    // Properties
    // ----------------------------------------
    property p_apb_answer;
        i_psel && !i_penable |=> ##1 o_pready;
    endproperty
    a_apb_answer: assert property (p_apb_answer) else $error("apb answer late");
    property p_err_ready;
        o_pslverr |-> o_pready && o_prdata == 32'h0;
    endproperty
    a_err_ready: assert property (p_err_ready) else $error("bad error answer");
    property p_dt_master;
        o_receive_or_data_pin_oe |-> ctrl_sh[SERIAL_PORT_ENABLE] && ctrl_sh[CLOCKED_MODE]
            && ctrl_sh[CLOCK_SOURCE_MASTER] && !ctrl_sh[SINGLE_RECEIVE_ENABLE] && !ctrl_sh[CONTINUOUS_RECEIVE_ENABLE];
    endproperty
    a_dt_master: assert property (p_dt_master) else $error("data driven outside master tx");
    property p_ck_drive;
        o_receive_or_data_pin_oe |-> o_transmit_or_clock_pin_oe;
    endproperty
    a_ck_drive: assert property (p_ck_drive) else $error("clock not driven");
    property p_ck_idle;
        $fell(o_receive_or_data_pin_oe) |-> $past(o_transmit_or_clock_pin) == $past(ctrl_sh[CLOCK_POLARITY_SELECT], 2);
    endproperty
    a_ck_idle: assert property (p_ck_idle) else $error("clock idle level wrong");
    property p_lead_change;
        o_receive_or_data_pin_oe && $past(o_receive_or_data_pin_oe) && $changed(o_receive_or_data_pin)
            && !$past(ctrl_wr, 2) |-> o_transmit_or_clock_pin != ctrl_sh[CLOCK_POLARITY_SELECT];
    endproperty
    a_lead_change: assert property (p_lead_change) else $error("data moved off leading edge");
    property p_wake_flag;
        wake_sh && $fell(i_receive_or_data_pin) |-> ##[2:8] o_receive_interrupt_flag;
    endproperty
    a_wake_flag: assert property (p_wake_flag) else $error("no wake flag");
    property p_read_clear;
        o_pready && !i_pwrite && i_paddr == ADDR_RXDATA && i_receive_or_data_pin && !wake_sh
            |-> ##2 !o_receive_interrupt_flag;
    endproperty
    a_read_clear: assert property (p_read_clear) else $error("flag not cleared by read");
endmodule
bind sbw_top sbw_top_props u_props (.*);
`default_nettype wire

// ---- tb/test_serial_break_wake_sync_master.sv ----
// Self-checking bench for the break, wake and synchronous master block.
// Assumes the node model and the port checker are compiled before it.
`timescale 1ns/1ps
`default_nettype none
module test_serial_break_wake_sync_master
    import sbw_pkg::*;
;
    localparam int BIT_CLKS = 12;
    logic clk = 1'h0;
    logic rst_n = 1'h0;
    logic psel = 1'h0;
    logic penable = 1'h0;
    logic pwrite = 1'h0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic rx_in;
    logic dt_out;
    logic dt_oe;
    logic tx_out;
    logic tx_oe;
    logic flag;
    logic node_rx;
    int bad_count = 0;
    int n_tests = 0;
    always #4 clk = ~clk;
    // The block drives the data pin in sync transmit, the node otherwise
    assign rx_in = dt_oe ? dt_out : node_rx;
    sbw_top uut (
        .i_ref_clk(clk), .i_reset_n(rst_n), .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
        .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
        .i_receive_or_data_pin(rx_in), .o_receive_or_data_pin(dt_out), .o_receive_or_data_pin_oe(dt_oe),
        .o_transmit_or_clock_pin(tx_out), .o_transmit_or_clock_pin_oe(tx_oe), .o_receive_interrupt_flag(flag)
    );
    sbw_node node (.i_tx_pin(tx_out), .i_tx_oe(tx_oe), .i_dt_pin(dt_out), .i_dt_oe(dt_oe), .o_rx_line(node_rx));
    task automatic print_verdict();
        if (bad_count == 0 && n_tests > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic give_up();
        bad_count++;
        $display("unexpected at %0t: wait ran out", $time);
        print_verdict();
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            bad_count++;
            $display("unexpected at %0t: got %h, wanted %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r,
                       output logic e);
        int t;
        @(posedge clk);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'h1;
        for (t = 0; t < 20 && pready !== 1'h1; t++) @(negedge clk);
        if (t >= 20) give_up();
        r = prdata;
        e = pslverr;
        @(posedge clk);
        psel <= 1'h0;
        penable <= 1'h0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(1'h1, a, d, r, e);
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] x);
        logic [31:0] r;
        logic e;
        apb(1'h0, a, x, r, e);
        check(r, x);
    endtask
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic s_regs();
        logic [31:0] r;
        logic e;
        rd_chk(ADDR_CTRL, 32'h0);
        apb(1'h0, 8'h14, 32'h0, r, e);
        check(32'(e), 32'h1);
        wr(ADDR_BAUD, 32'(BIT_CLKS));
        rd_chk(ADDR_BAUD, 32'(BIT_CLKS));
    endtask
    task automatic s_wake();
        logic [31:0] r;
        logic e;
        int t;
        rd_chk(ADDR_STATUS, 32'hE);
        wr(ADDR_CTRL, 32'hC1);
        fork
            node.send_low(11);
        join_none
        for (t = 0; t < 50 && flag !== 1'h1; t++) @(posedge clk);
        if (t >= 50) give_up();
        rd_chk(ADDR_CTRL, 32'hC1);
        for (t = 0; t < 400 && node_rx !== 1'h1; t++) @(posedge clk);
        repeat (8) @(posedge clk);
        rd_chk(ADDR_CTRL, 32'h41);
        rd_chk(ADDR_STATUS, 32'hF);
        apb(1'h0, ADDR_RXDATA, 32'h0, r, e);
        rd_chk(ADDR_STATUS, 32'hE);
    endtask
    task automatic s_break_rx();
        logic [31:0] r;
        logic e;
        node.send_low(10);
        repeat (30) @(posedge clk);
        apb(1'h0, ADDR_STATUS, 32'h0, r, e);
        check(r & 32'h11, 32'h11);
        rd_chk(ADDR_RXDATA, 32'h0);
    endtask
    task automatic s_break_tx();
        logic [31:0] r;
        logic e;
        int t;
        node.async_on = 1'h1;
        wr(ADDR_CTRL, 32'h19);
        wr(ADDR_TXDATA, 32'hA5);
        wr(ADDR_TXDATA, 32'h55);
        apb(1'h0, ADDR_STATUS, 32'h0, r, e);
        check(r & 32'h4, 32'h0);
        for (t = 0; t < 3000 && node.flen.size() < 2; t++) @(posedge clk);
        if (t >= 3000) give_up();
        check(node.flen[0], 32'hE);
        check(node.fbyte[0], 32'h0);
        check(node.flen[1], 32'hA);
        check(node.fbyte[1], 32'h55);
        repeat (20) @(posedge clk);
        rd_chk(ADDR_CTRL, 32'h9);
        rd_chk(ADDR_STATUS, 32'h1E);
        node.async_on = 1'h0;
    endtask
    task automatic s_sync();
        logic [31:0] r;
        logic e;
        int t;
        for (int p = 0; p < 4; p++)
        begin
            wr(ADDR_CTRL, 32'h8F | 32'(p << 8));
            repeat (2) @(posedge clk);
            node.ckpol = p[0];
            node.scount = 0;
            wr(ADDR_TXDATA, 32'h96);
            wr(ADDR_TXDATA, 32'h3C);
            apb(1'h0, ADDR_STATUS, 32'h0, r, e);
            check(r & 32'h2, 32'h0);
            for (t = 0; t < 3000 && node.scount < 16; t++) @(posedge clk);
            if (t >= 3000) give_up();
            repeat (BIT_CLKS) @(posedge clk);
            check(node.sbits, p[1] ? 32'hC369 : 32'h3C96);
            check(node.scount, 32'h10);
            check(tx_out, p[0]);
            check(flag, 32'h0);
        end
        wr(ADDR_CTRL, 32'h0);
    endtask
    initial
    begin
        repeat (12) @(posedge clk);
        rst_n <= 1'h1;
        node.bit_ns = BIT_CLKS * 8;
        s_regs();
        s_wake();
        s_break_rx();
        s_break_tx();
        s_sync();
        print_verdict();
    end
endmodule
`default_nettype wire
